// ### hw/beam_timer.sv
`timescale 1ns/10ps
`default_nettype none
module beam_timer
  import game_port_pkg::*;
(
  input  wire logic       pclk,
  input  wire logic       presetn,
  output logic            line_stb,
  output logic [8:0]      vpos,
  output logic [8:0]      hpos,
  output logic            long_frame
);
  typedef struct packed {
    logic [8:0] h;
    logic [8:0] v;
    logic       lf;
    logic       stb;
  } bt_s;
  bt_s st_r, st_nxt;

  always_comb begin
    st_nxt     = st_r;
    st_nxt.stb = 1'b0;
    if (st_r.h == {CLKS_PER_HALF[7:0], 1'b0} - 9'h001) begin
      st_nxt.h   = '0;
      st_nxt.stb = 1'b1;
      if (st_r.v == LINES_PER_FIELD) begin
        st_nxt.v  = '0;
        st_nxt.lf = ~st_r.lf;
      end else begin
        st_nxt.v = st_r.v + 9'h001;
      end
    end else begin
      st_nxt.h = st_r.h + 9'h001;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign line_stb   = st_r.stb;
  assign vpos       = st_r.v;
  assign hpos       = st_r.h;
  assign long_frame = st_r.lf;

  a_one_strobe: assert property (@(posedge pclk)
    disable iff (!presetn)
    st_r.stb |=> !st_r.stb)
    else $error("line strobe too long");
endmodule
`default_nettype wire

// ### hw/game_port_input.sv
// The APB slave port was chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
module game_port_input
  import game_port_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [23:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic [3:0]  port1_dir_n,
  input  wire logic [3:0]  port2_dir_n,
  input  wire logic        pen_trigger,
  input  wire logic [3:0]  pot_pin_in,
  input  wire logic [3:0]  pot_above,
  output logic      [3:0]  pot_pin_out,
  output logic      [3:0]  pot_pin_oe_n,
  output logic      [3:0]  pot_dump
);
  typedef struct packed {
    logic [1:0][3:0] dir_s1;
    logic [1:0][3:0] dir_s2;
    logic [2:0]      pen_s;
    logic [3:0]      pin_s1;
    logic [3:0]      pin_s2;
    logic [3:0]      abv_s1;
    logic [3:0]      abv_s2;
    logic [15:0]     pot_ctrl;
    logic [15:0]     bpl_ctrl;
    logic            frozen;
    logic [8:0]      cap_v;
    logic [8:0]      cap_h;
    logic            cap_lf;
    logic            start;
    logic [31:0]     rdata;
    logic            ready;
    logic            err;
    logic [3:0]      pout;
    logic [3:0]      poe_n;
    logic [3:0]      dump;
  } top_s;
  top_s st_r, st_nxt;

  logic       line_stb;
  logic [8:0] vpos;
  logic [8:0] hpos;
  logic       long_frame;
  logic [3:0] oe;
  logic [3:0] dout;
  logic       setup;
  logic       pen_edge;
  logic       access;
  logic       release_line;

  pot_bus_if pbus ();

  beam_timer u_beam (
    .pclk       (pclk),
    .presetn    (presetn),
    .line_stb   (line_stb),
    .vpos       (vpos),
    .hpos       (hpos),
    .long_frame (long_frame)
  );

  pot_counters u_pots (
    .pclk    (pclk),
    .presetn (presetn),
    .bus     (pbus.chan)
  );

  // Map of pins: 0 port1 pin5, 1 port1 pin9, 2 port2 pin5, 3 port2 pin9
  assign oe   = {st_r.pot_ctrl[15], st_r.pot_ctrl[13],
                 st_r.pot_ctrl[11], st_r.pot_ctrl[9]};
  assign dout = {st_r.pot_ctrl[14], st_r.pot_ctrl[12],
                 st_r.pot_ctrl[10], st_r.pot_ctrl[8]};

  assign pbus.line_stb = line_stb;
  assign pbus.start    = st_r.start;
  assign pbus.above    = st_r.abv_s2;
  assign pbus.oe       = oe;

  function automatic logic [15:0] motion_word(input logic [3:0] dn);
    logic [3:0]  cl;
    logic [15:0] w;
    cl = ~dn;
    w  = 16'h0000;
    w[RIGHT_BIT]     = cl[3];
    w[LEFT_BIT]      = cl[2];
    w[RIGHT_BIT - 1] = cl[3] ^ cl[1];
    w[LEFT_BIT - 1]  = cl[2] ^ cl[0];
    return w;
  endfunction

  function automatic logic [15:0] prop_word(input logic [7:0] y,
                                            input logic [7:0] x);
    return {y, x};
  endfunction

  assign setup        = psel && !penable;
  assign access       = psel && penable && st_r.ready;
  assign pen_edge     = st_r.pen_s[1] && !st_r.pen_s[2];
  assign release_line = line_stb && vpos == VBLANK_END_LINE;

  always_comb begin
    logic [8:0] rv;
    logic [8:0] rh;
    logic       rlf;
    rv     = '0;
    rh     = '0;
    rlf    = 1'b0;
    st_nxt = st_r;
    st_nxt.dir_s1 = {port2_dir_n, port1_dir_n};
    st_nxt.dir_s2 = st_r.dir_s1;
    st_nxt.pen_s  = {st_r.pen_s[1:0], pen_trigger};
    st_nxt.pin_s1 = pot_pin_in;
    st_nxt.pin_s2 = st_r.pin_s1;
    st_nxt.abv_s1 = pot_above;
    st_nxt.abv_s2 = st_r.abv_s1;
    st_nxt.start  = 1'b0;
    st_nxt.ready  = 1'b0;
    st_nxt.err    = 1'b0;

    if (release_line) begin
      st_nxt.frozen = 1'b0;
    end
    if (st_r.bpl_ctrl[PEN_EN_BIT] &&
        (!st_r.frozen || release_line)) begin
      if (pen_edge) begin
        st_nxt.frozen = 1'b1;
        st_nxt.cap_v  = vpos;
        st_nxt.cap_h  = hpos;
        st_nxt.cap_lf = long_frame;
      end else if (line_stb && vpos == LINES_PER_FIELD) begin
        st_nxt.frozen = 1'b1;
        st_nxt.cap_v  = vpos;
        st_nxt.cap_h  = hpos;
        st_nxt.cap_lf = long_frame;
      end
    end

    if (st_r.frozen) begin
      rv  = st_r.cap_v;
      rh  = st_r.cap_h;
      rlf = st_r.cap_lf;
    end else begin
      rv  = vpos;
      rh  = hpos;
      rlf = long_frame;
    end

    if (setup) begin
      st_nxt.ready = 1'b1;
      st_nxt.rdata = 32'h0000_0000;
      if (pwrite) begin
        unique case (paddr)
          POT_WRITE_OFF, BPL_CTRL_OFF: st_nxt.err = 1'b0;
          default:                     st_nxt.err = 1'b1;
        endcase
      end else begin
        unique case (paddr)
          BEAM_HIGH_OFF:
            st_nxt.rdata = {16'h0000, rlf, CHIP_ID, rv[8]};
          BEAM_LOW_OFF:
            st_nxt.rdata = {16'h0000, rv[7:0], rh[8:1]};
          PORT1_MOT_OFF:
            st_nxt.rdata = {16'h0000, motion_word(st_r.dir_s2[0])};
          PORT2_MOT_OFF:
            st_nxt.rdata = {16'h0000, motion_word(st_r.dir_s2[1])};
          PORT1_PROP_OFF:
            st_nxt.rdata = {16'h0000,
                            prop_word(pbus.count[1], pbus.count[0])};
          PORT2_PROP_OFF:
            st_nxt.rdata = {16'h0000,
                            prop_word(pbus.count[3], pbus.count[2])};
          POT_READ_OFF:
            st_nxt.rdata = {16'h0000, st_r.pin_s2[3], st_r.pin_s2[3],
                            st_r.pin_s2[2], st_r.pin_s2[2],
                            st_r.pin_s2[1], st_r.pin_s2[1],
                            st_r.pin_s2[0], st_r.pin_s2[0],
                            CHIP_REV, 1'b0};
          default: st_nxt.err = 1'b1;
        endcase
      end
    end

    // Writes land at the access edge, when pready is seen
    if (access && pwrite) begin
      unique case (paddr)
        POT_WRITE_OFF: begin
          st_nxt.pot_ctrl = pwdata[15:0];
          st_nxt.start    = pwdata[START_BIT];
        end
        BPL_CTRL_OFF: st_nxt.bpl_ctrl = pwdata[15:0];
        default: begin
        end
      endcase
    end

    st_nxt.pout  = dout;
    st_nxt.poe_n = ~oe;
    st_nxt.dump  = ~oe & {4{st_r.start}};
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r          <= '0;
      st_r.dir_s1   <= '1;
      st_r.dir_s2   <= '1;
      st_r.pin_s1   <= '1;
      st_r.pin_s2   <= '1;
      st_r.pot_ctrl <= POT_CTRL_RESET;
      st_r.poe_n    <= '1;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign prdata       = st_r.rdata;
  assign pready       = st_r.ready;
  assign pslverr      = st_r.err;
  assign pot_pin_out  = st_r.pout;
  assign pot_pin_oe_n = st_r.poe_n;
  assign pot_dump     = st_r.dump;

  sequence s_trig_armed;
    st_r.bpl_ctrl[PEN_EN_BIT] && pen_edge &&
    (!st_r.frozen || release_line);
  endsequence

  sequence s_start_cmd;
    access && pwrite && paddr == POT_WRITE_OFF && pwdata[START_BIT];
  endsequence

  sequence s_pot_write;
    access && pwrite && paddr == POT_WRITE_OFF;
  endsequence

  sequence s_cleared;
    st_r.start ##1 pbus.count[0] == 8'h00;
  endsequence

  a_pen_freeze: assert property (@(posedge pclk)
    disable iff (!presetn)
    s_trig_armed |=> st_r.frozen && st_r.cap_v == $past(vpos))
    else $error("pen trigger not captured");

  a_pen_disabled: assert property (@(posedge pclk)
    disable iff (!presetn)
    !st_r.bpl_ctrl[PEN_EN_BIT] && !st_r.frozen |=> !st_r.frozen)
    else $error("latch without enable");

  a_release_line: assert property (@(posedge pclk)
    disable iff (!presetn)
    release_line && !(st_r.bpl_ctrl[PEN_EN_BIT] && pen_edge)
    |=> !st_r.frozen)
    else $error("freeze not released");

  a_pen_hold: assert property (@(posedge pclk)
    disable iff (!presetn)
    st_r.frozen && !release_line |=> st_r.frozen && $stable(st_r.cap_v))
    else $error("frozen position moved");

  a_field_freeze: assert property (@(posedge pclk)
    disable iff (!presetn)
    st_r.bpl_ctrl[PEN_EN_BIT] && !st_r.frozen && line_stb &&
    vpos == LINES_PER_FIELD |=> st_r.frozen)
    else $error("field end did not freeze");

  a_frozen_read: assert property (@(posedge pclk)
    disable iff (!presetn)
    st_r.frozen && !release_line && setup && !pwrite &&
    paddr == BEAM_LOW_OFF
    |=> prdata[15:0] == {st_r.cap_v[7:0], st_r.cap_h[8:1]})
    else $error("frozen read shows live beam");

  a_start_pulse: assert property (@(posedge pclk)
    disable iff (!presetn)
    s_start_cmd |=> s_cleared)
    else $error("start did not clear counters");

  a_no_start: assert property (@(posedge pclk)
    disable iff (!presetn)
    !(access && pwrite && paddr == POT_WRITE_OFF) |=> !st_r.start)
    else $error("start without command");

  a_pot_write: assert property (@(posedge pclk)
    disable iff (!presetn)
    s_pot_write |=> {16'h0000, st_r.pot_ctrl} ==
    ($past(pwdata) & 32'h0000_ffff))
    else $error("pot control not written");

  a_oe_drive: assert property (@(posedge pclk)
    disable iff (!presetn)
    st_r.pot_ctrl[15] |=> !pot_pin_oe_n[3] && pot_pin_out[3] ==
    $past(st_r.pot_ctrl[14]))
    else $error("pin not driven");

  a_oe_low: assert property (@(posedge pclk)
    disable iff (!presetn)
    st_r.pot_ctrl[9] |=> !pot_pin_oe_n[0] && pot_pin_out[0] ==
    $past(st_r.pot_ctrl[8]))
    else $error("low pin not driven");

  a_oe_off: assert property (@(posedge pclk)
    disable iff (!presetn)
    !st_r.pot_ctrl[15] |=> pot_pin_oe_n[3])
    else $error("pin driven without enable");

  a_dump_masked: assert property (@(posedge pclk)
    disable iff (!presetn)
    (pot_dump & ~pot_pin_oe_n) == 4'h0)
    else $error("driven pin dumped");

  a_apb_answer: assert property (@(posedge pclk)
    disable iff (!presetn)
    setup |=> pready)
    else $error("no answer");

  a_ready_pulse: assert property (@(posedge pclk)
    disable iff (!presetn)
    pready |=> !pready)
    else $error("ready held too long");

  a_err_ready: assert property (@(posedge pclk)
    disable iff (!presetn)
    pslverr |-> pready)
    else $error("error without ready");
endmodule
`default_nettype wire

// ### hw/game_port_pkg.sv
package game_port_pkg;
  localparam logic [23:0] BEAM_HIGH_OFF   = 24'hdff004;
  localparam logic [23:0] BEAM_LOW_OFF    = 24'hdff006;
  localparam logic [23:0] PORT1_MOT_OFF   = 24'hdff00a;
  localparam logic [23:0] PORT2_MOT_OFF   = 24'hdff00c;
  localparam logic [23:0] PORT1_PROP_OFF  = 24'hdff012;
  localparam logic [23:0] PORT2_PROP_OFF  = 24'hdff014;
  localparam logic [23:0] POT_READ_OFF    = 24'hdff016;
  localparam logic [23:0] POT_WRITE_OFF   = 24'hdff034;
  localparam logic [23:0] BPL_CTRL_OFF    = 24'hdff100;
  localparam int          RIGHT_BIT       = 1;
  localparam int          LEFT_BIT        = 9;
  localparam int          PEN_EN_BIT      = 3;
  localparam int          START_BIT       = 0;
  localparam logic [3:0]  DISCHARGE_LINES = 4'h8;
  localparam logic [8:0]  VBLANK_END_LINE = 9'h014;
  localparam logic [13:0] CHIP_ID         = 14'h0000;
  localparam logic [6:0]  CHIP_REV        = 7'h00;
  localparam logic [8:0]  LINES_PER_FIELD = 9'h106;
  localparam logic [8:0]  CLKS_PER_HALF   = 9'h0e3;
  localparam logic [15:0] POT_CTRL_RESET  = 16'h0000;
endpackage

// ### hw/pot_bus_if.sv
`timescale 1ns/10ps
`default_nettype none
interface pot_bus_if;
  logic       line_stb;
  logic       start;
  logic [3:0] above;
  logic [3:0] oe;
  logic [7:0] count [4];
  modport ctrl (output line_stb, output start, output above, output oe,
                input count);
  modport chan (input line_stb, input start, input above, input oe,
                output count);
endinterface
`default_nettype wire

// ### hw/pot_counters.sv
`timescale 1ns/10ps
`default_nettype none
module pot_counters
  import game_port_pkg::*;
(
  input  wire logic pclk,
  input  wire logic presetn,
  pot_bus_if.chan   bus
);
  typedef struct packed {
    logic [3:0]      hold;
    logic [3:0][7:0] cnt;
    logic [3:0]      dump;
  } pot_s;
  pot_s st_r, st_nxt;

  always_comb begin
    st_nxt = st_r;
    if (bus.start) begin
      st_nxt.cnt  = '0;
      st_nxt.hold = '0;
      st_nxt.dump = DISCHARGE_LINES;
    end else if (bus.line_stb) begin
      if (st_r.dump != 4'h0) begin
        st_nxt.dump = st_r.dump - 4'h1;
      end else begin
        for (int i = 0; i < 4; i++) begin
          if (bus.above[i] || bus.oe[i]) begin
            st_nxt.hold[i] = 1'b1;
          end else if (!st_r.hold[i]) begin
            st_nxt.cnt[i] = st_r.cnt[i] + 8'h01;
          end
        end
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  always_comb begin
    for (int i = 0; i < 4; i++) begin
      bus.count[i] = st_r.cnt[i];
    end
  end

  a_hold_keeps: assert property (@(posedge pclk)
    disable iff (!presetn)
    st_r.hold[0] && !bus.start |=> $stable(st_r.cnt[0]))
    else $error("held count changed");
  a_dump_freeze: assert property (@(posedge pclk)
    disable iff (!presetn)
    bus.start |=> st_r.cnt[0] == 8'h00 && st_r.dump == DISCHARGE_LINES)
    else $error("start did not clear");
endmodule
`default_nettype wire

// ### tb/controller_model.sv
`timescale 1ns/10ps
`default_nettype none
module controller_model #(
  parameter logic [31:0] KS = 32'h0
) (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic [3:0] sw1,
  input  wire logic [3:0] sw2,
  input  wire logic       pen_fire,
  input  wire logic [3:0] pot_dump,
  output logic      [3:0] port1_dir_n,
  output logic      [3:0] port2_dir_n,
  output logic            pen_trigger,
  output logic      [3:0] pot_above
);
  int cnt [4];
  // Closed switch shorts line to ground
  assign port1_dir_n = ~sw1;
  assign port2_dir_n = ~sw2;
  assign pen_trigger = pen_fire;
  // Cap charges from dump, crosses mid-line
  always @(posedge pclk or negedge presetn) begin
    for (int i = 0; i < 4; i++) begin
      if (!presetn) begin
        cnt[i] <= 1 << 20;
      end else if (pot_dump[i]) begin
        cnt[i] <= 0;
      end else begin
        cnt[i] <= cnt[i] + 1;
      end
    end
  end
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      pot_above[i] = cnt[i] >= (8 + int'(KS[i*8+:8])) * 454;
    end
  end
endmodule
`default_nettype wire

// ### tb/game_port_input_readout_tb.sv
`timescale 1ns/10ps
`default_nettype none
module game_port_input_readout_tb;
  import game_port_pkg::*;
  typedef struct packed {
    logic [31:0] val;
    logic [31:0] msk;
    logic        err;
  } note_s;
  localparam int LINE = 454;
  localparam logic [31:0] KS = 32'h28190a03;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [23:0] paddr = 24'h0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [3:0]  sw1 = 4'h0;
  logic [3:0]  sw2 = 4'h0;
  logic [3:0]  pin_ext = 4'h0;
  logic [3:0]  dir1_n, dir2_n, pot_above, pot_dump;
  logic [3:0]  pot_pin_in, pot_pin_out, pot_pin_oe_n;
  logic        pen_fire = 1'b0;
  logic        pen_trigger;
  logic [31:0] seed = 32'h61;
  logic [3:0]  p;
  int          num_errors = 0;
  int          cmp_count = 0;
  int          cyc = 0;
  note_s       notes [$];
  note_s       n;
  always #10 pclk = ~pclk;
  assign pot_pin_in = (pot_pin_oe_n & pin_ext) | (~pot_pin_oe_n & pot_pin_out);
  game_port_input dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .port1_dir_n(dir1_n), .port2_dir_n(dir2_n), .pen_trigger(pen_trigger),
    .pot_pin_in(pot_pin_in), .pot_above(pot_above),
    .pot_pin_out(pot_pin_out), .pot_pin_oe_n(pot_pin_oe_n),
    .pot_dump(pot_dump));
  controller_model #(.KS(KS)) partner (.pclk(pclk), .presetn(presetn),
    .sw1(sw1), .sw2(sw2), .pen_fire(pen_fire), .pot_dump(pot_dump),
    .port1_dir_n(dir1_n), .port2_dir_n(dir2_n),
    .pen_trigger(pen_trigger), .pot_above(pot_above));
  function automatic logic [31:0] xs(input logic [31:0] x);
    logic [31:0] y;
    y = x ^ (x << 13);
    y = y ^ (y >> 17);
    return y ^ (y << 5);
  endfunction
  // Switches: [3] right [2] left [1] back [0] forward
  function automatic logic [31:0] mot(input logic [3:0] c);
    return {22'h0, c[2], c[2] ^ c[0], 6'h0, c[3], c[3] ^ c[1]};
  endfunction
  task automatic cmp(input logic [31:0] g, input logic [31:0] e);
    cmp_count++;
    if (g !== e) begin
      num_errors++;
      $display("ERROR t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic xfer(input logic wr, input logic [23:0] a,
                      input logic [31:0] d, input logic [31:0] m,
                      input logic e);
    notes.push_back('{d, wr ? 32'h0 : m, e});
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wait_line(input int l);
    while (cyc < l * LINE + LINE / 2) @(posedge pclk);
  endtask
  task automatic pen;
    pen_fire <= 1'b1;
    repeat (4) @(posedge pclk);
    pen_fire <= 1'b0;
  endtask
  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) cyc <= 0;
    else cyc <= cyc + 1;
  end
  // Monitor: oldest note against each answer
  always @(posedge pclk) begin
    if (psel && penable && pready === 1'b1) begin
      n = notes.pop_front();
      cmp(prdata & n.msk, n.val & n.msk);
      cmp({31'h0, pslverr}, {31'h0, n.err});
    end
  end
  initial begin
    repeat (80000) @(posedge pclk);
    num_errors++;
    report_and_stop();
  end
  initial begin
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < 16; i++) begin
      sw1 <= i[3:0];
      sw2 <= ~i[3:0];
      repeat (4) @(posedge pclk);
      xfer(0, PORT1_MOT_OFF, mot(i[3:0]), 32'h0303, 0);
      xfer(0, PORT2_MOT_OFF, mot(~i[3:0]), 32'h0303, 0);
    end
    xfer(1, POT_READ_OFF, 32'h0, 32'h0, 1);
    xfer(0, POT_WRITE_OFF, 32'h0, 32'h0, 1);
    xfer(0, 24'hdff200, 32'h0, 32'h0, 1);
    wait_line(2);
    xfer(1, POT_WRITE_OFF, 32'h0001, 0, 0);
    for (int l = 60; l <= 64; l += 4) begin
      wait_line(l);
      xfer(0, PORT1_PROP_OFF, {16'h0, KS[15:0]}, '1, 0);
      xfer(0, PORT2_PROP_OFF, {16'h0, KS[31:16]}, '1, 0);
    end
    wait_line(65);
    xfer(1, POT_WRITE_OFF, 32'h0001, 0, 0);
    wait_line(66);
    xfer(0, PORT1_PROP_OFF, 32'h0, '1, 0);
    xfer(0, PORT2_PROP_OFF, 32'h0, '1, 0);
    for (int j = 0; j < 8; j++) begin
      if (j == 0) xfer(1, POT_WRITE_OFF, 32'hf100, 0, 0);
      if (j == 4) xfer(1, POT_WRITE_OFF, 32'h0000, 0, 0);
      seed = xs(seed);
      pin_ext <= seed[3:0];
      repeat (4) @(posedge pclk);
      p = (j < 4) ? {2'b11, seed[1:0]} : seed[3:0];
      cmp({pot_pin_oe_n, j < 4 ? pot_pin_out[3:2] : 2'b11},
          {j < 4 ? 4'b0011 : 4'hf, 2'b11});
      xfer(0, POT_READ_OFF, {16'h0, p[3], p[3], p[2], p[2], p[1], p[1],
           p[0], p[0], CHIP_REV, 1'b0}, '1, 0);
    end
    wait_line(70);
    pen();
    wait_line(75);
    xfer(0, BEAM_LOW_OFF, {16'h0, 8'd75, 8'h0}, 32'hff00, 0);
    xfer(1, BPL_CTRL_OFF, 32'h0008, 0, 0);
    wait_line(100);
    pen();
    for (int l = 105; l <= 125; l += 10) begin
      wait_line(l);
      xfer(0, BEAM_LOW_OFF, {16'h0, 8'd100, 8'h0}, 32'hff00, 0);
      xfer(0, BEAM_HIGH_OFF, {17'h0, CHIP_ID, 1'b0}, 32'h7fff, 0);
    end
    report_and_stop();
  end
endmodule
`default_nettype wire
